// ==== rtl/lcr_bank.sv ====
// APB register bank for regulators six and seven and the reset output
//
// How it works
// - Voltage register: six-bit code in bits 5:0, bits 7:6 read zero.
// - Control bit 7 turns the regulator on when one, off when zero.
// - Control bit 6 lets a shut-down regulator drain its output to ground.
// - Control bit 5 selects quiet low-current mode when one.
// - Control bit 0 reads the synced power-good level, read only.
// - Reset output stays low for the full delay after supplies are good.
// - Reset output only pulls low; an external pull-up makes it high.
`timescale 1ns/100ps
`include "lcr_map.svh"
module lcr_bank #(
   parameter int unsigned RST_DELAY_CYC = `LCR_RST_DELAY_CYC,
   parameter logic [5:0]  SIX_VCODE_RST = `LCR_VCODE_RST,
   parameter logic [5:0]  SEVEN_VCODE_RST = `LCR_VCODE_RST
) (
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   input  wire logic [`LCR_ADDR_W-1:0] paddr,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [31:0]            pwdata,
   input  wire logic [3:0]             pstrb,
   output logic      [31:0]            prdata,
   output logic                        pready,
   output logic                        pslverr,
   output logic                        irq,
   input  wire logic                   ldo_six_pgood_in,
   input  wire logic                   ldo_seven_pgood_in,
   output logic      [5:0]             ldo_six_voltage_code,
   output logic                        ldo_six_enable,
   output logic                        ldo_six_shutdown_drain,
   output logic                        ldo_six_quiet_supply_mode,
   output logic      [5:0]             ldo_seven_voltage_code,
   output logic                        ldo_seven_enable,
   output logic                        ldo_seven_shutdown_drain,
   output logic                        ldo_seven_quiet_supply_mode,
   input  wire logic                   reset_out_n_in,
   output logic                        reset_out_n_out,
   output logic                        reset_out_n_oe
);
   localparam int IW = `LCR_IRQ_W;

   // Address decode
   wire setup    = psel & ~penable;
   wire access   = psel & penable;
   wire hit_v6   = (paddr == `LCR_BYTE_ADDR(`LCR_IDX_SIX_VOLT));
   wire hit_c6   = (paddr == `LCR_BYTE_ADDR(`LCR_IDX_SIX_CTRL));
   wire hit_v7   = (paddr == `LCR_BYTE_ADDR(`LCR_IDX_SEVEN_VOLT));
   wire hit_c7   = (paddr == `LCR_BYTE_ADDR(`LCR_IDX_SEVEN_CTRL));
   wire hit_ist  = (paddr == `LCR_BYTE_ADDR(`LCR_IDX_IRQ_STATUS));
   wire hit_imk  = (paddr == `LCR_BYTE_ADDR(`LCR_IDX_IRQ_MASK));
   wire hit_sys  = (paddr == `LCR_BYTE_ADDR(`LCR_IDX_SYS_STATUS));
   wire hit_any  = hit_v6 | hit_c6 | hit_v7 | hit_c7 | hit_ist | hit_imk | hit_sys;
   // Only byte lane 0 carries data; a write without it is a no-op
   wire wr_ok    = access & pwrite & hit_any & pstrb[0];
   wire wr_v6    = wr_ok & hit_v6;
   wire wr_c6    = wr_ok & hit_c6;
   wire wr_v7    = wr_ok & hit_v7;
   wire wr_c7    = wr_ok & hit_c7;
   wire wr_ist   = wr_ok & hit_ist;
   wire wr_imk   = wr_ok & hit_imk;
   wire [7:0] wbyte = pwdata[7:0];

   // Channel state
   logic [7:0] v6_rd, c6_rd, v7_rd, c7_rd;
   logic       pg6, pg7, pg6_rise, pg6_fall, pg7_rise, pg7_fall;
   logic       hold_low, rst_done;

   lcr_ldo_chan #(
      .VCODE_RST (SIX_VCODE_RST)
   ) u_six (
      .pclk         (pclk),
      .presetn      (presetn),
      .wr_volt      (wr_v6),
      .wr_ctrl      (wr_c6),
      .wdata        (wbyte),
      .pgood_raw    (ldo_six_pgood_in),
      .voltage_code (ldo_six_voltage_code),
      .enable       (ldo_six_enable),
      .drain_on     (ldo_six_shutdown_drain),
      .quiet        (ldo_six_quiet_supply_mode),
      .pgood        (pg6),
      .volt_rd      (v6_rd),
      .ctrl_rd      (c6_rd),
      .pg_rise      (pg6_rise),
      .pg_fall      (pg6_fall)
   );

   lcr_ldo_chan #(
      .VCODE_RST (SEVEN_VCODE_RST)
   ) u_seven (
      .pclk         (pclk),
      .presetn      (presetn),
      .wr_volt      (wr_v7),
      .wr_ctrl      (wr_c7),
      .wdata        (wbyte),
      .pgood_raw    (ldo_seven_pgood_in),
      .voltage_code (ldo_seven_voltage_code),
      .enable       (ldo_seven_enable),
      .drain_on     (ldo_seven_shutdown_drain),
      .quiet        (ldo_seven_quiet_supply_mode),
      .pgood        (pg7),
      .volt_rd      (v7_rd),
      .ctrl_rd      (c7_rd),
      .pg_rise      (pg7_rise),
      .pg_fall      (pg7_fall)
   );

   // A disabled regulator does not block the reset release
   wire power_ok = (~ldo_six_enable | pg6) & (~ldo_seven_enable | pg7);

   lcr_rst_timer #(
      .DELAY_CYC (RST_DELAY_CYC)
   ) u_rst (
      .pclk     (pclk),
      .presetn  (presetn),
      .power_ok (power_ok),
      .hold_low (hold_low),
      .released (rst_done)
   );

   // Open-drain: drive value is always low, enable alone decides
   assign reset_out_n_out = 1'b0;
   assign reset_out_n_oe  = hold_low;

   // Pin readback; the line is outside pclk's domain
   logic pin_meta_q, pin_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_meta_q <= 1'b0;
         pin_q      <= 1'b0;
      end else begin
         pin_meta_q <= reset_out_n_in;
         pin_q      <= pin_meta_q;
      end
   end

   // Interrupt status and mask
   logic [IW-1:0] ist_q, imk_q;
   wire  [IW-1:0] ev_set = {rst_done, pg7_fall, pg7_rise, pg6_fall, pg6_rise};
   wire  [IW-1:0] ev_clr = wr_ist ? wbyte[IW-1:0] : '0;
   // Set beats clear so an event in the clearing cycle survives
   wire  [IW-1:0] ist_d  = (ist_q & ~ev_clr) | ev_set;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ist_q <= `LCR_IRQ_RST;
         imk_q <= `LCR_IRQ_RST;
      end else begin
         ist_q <= ist_d;
         if (wr_imk) begin
            imk_q <= wbyte[IW-1:0];
         end
      end
   end

   assign irq = |(ist_q & imk_q);

   // Read data is captured in the setup phase so prdata comes from a flop
   wire [7:0] sys_rd = {5'h00, hold_low, power_ok, pin_q};
   wire [7:0] rd_byte =
      hit_v6  ? v6_rd :
      hit_c6  ? c6_rd :
      hit_v7  ? v7_rd :
      hit_c7  ? c7_rd :
      hit_ist ? {{(8-IW){1'b0}}, ist_q} :
      hit_imk ? {{(8-IW){1'b0}}, imk_q} :
      hit_sys ? sys_rd : 8'h00;
   logic [31:0] prdata_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
      end else if (setup & ~pwrite) begin
         prdata_q <= {24'h00_0000, rd_byte};
      end
   end

   assign prdata  = prdata_q;
   assign pready  = 1'b1;
   assign pslverr = access & ~hit_any;

   // Checks
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   wire rd_acc = access & ~pwrite;

   property p_vcode_write;
      wr_v6 |=> ldo_six_voltage_code == $past(pwdata[5:0]);
   endproperty
   a_vcode_write: assert property (p_vcode_write)
      else $error("Voltage code not taken from write");

   property p_vcode_read;
      (rd_acc && hit_v7) |-> (prdata[7:6] == 2'b00 && prdata[5:0] == ldo_seven_voltage_code);
   endproperty
   a_vcode_read: assert property (p_vcode_read)
      else $error("Voltage register read wrong");

   property p_enable_write;
      wr_c6 |=> ldo_six_enable == $past(pwdata[7]) ##1 ldo_six_enable == $past(pwdata[7], 2);
   endproperty
   a_enable_write: assert property (p_enable_write)
      else $error("Enable bit did not follow write");

   property p_drain_off_only;
      ldo_seven_shutdown_drain == (c7_rd[`LCR_CTRL_DRAIN_BIT] && !ldo_seven_enable);
   endproperty
   a_drain_off_only: assert property (p_drain_off_only)
      else $error("Drain output disagrees with control bits");

   property p_drain_on;
      (wr_c6 && !pwdata[7] && pwdata[6]) |=> ldo_six_shutdown_drain;
   endproperty
   a_drain_on: assert property (p_drain_on)
      else $error("Drain not active in shutdown");

   property p_quiet_write;
      wr_c7 |=> ldo_seven_quiet_supply_mode == $past(pwdata[5]);
   endproperty
   a_quiet_write: assert property (p_quiet_write)
      else $error("Quiet mode did not follow write");

   property p_pgood_read;
      (rd_acc && hit_c6) |-> prdata[0] == $past(pg6);
   endproperty
   a_pgood_read: assert property (p_pgood_read)
      else $error("Power-good bit read wrong");

   property p_ctrl_rsvd;
      (rd_acc && (hit_c6 || hit_c7)) |-> prdata[4:1] == 4'h0;
   endproperty
   a_ctrl_rsvd: assert property (p_ctrl_rsvd)
      else $error("Reserved control bits not zero");

   // Pin readback lags the enable by the two sync stages
   property p_open_drain;
      $past(reset_out_n_oe, 2) |-> !pin_q && !reset_out_n_out;
   endproperty
   a_open_drain: assert property (p_open_drain)
      else $error("Reset output drives high");

   property p_irq_event;
      (pg6_rise && imk_q[`LCR_IRQ_SIX_RISE]) |=> irq && ist_q[`LCR_IRQ_SIX_RISE];
   endproperty
   a_irq_event: assert property (p_irq_event)
      else $error("Interrupt not raised on event");

   property p_vcode_hold;
      !wr_v6 |=> $stable(ldo_six_voltage_code);
   endproperty
   a_vcode_hold: assert property (p_vcode_hold)
      else $error("Voltage code changed without a write");

   property p_volt_rsvd;
      (rd_acc && (hit_v6 || hit_v7)) |-> prdata[7:6] == 2'b00;
   endproperty
   a_volt_rsvd: assert property (p_volt_rsvd)
      else $error("Reserved voltage bits not zero");

   property p_strb_ignore;
      (access && pwrite && hit_v6 && !pstrb[0]) |=> $stable(ldo_six_voltage_code);
   endproperty
   a_strb_ignore: assert property (p_strb_ignore)
      else $error("Write without byte lane 0 took effect");

   property p_enable_off;
      (wr_c7 && !pwdata[7]) |=> !ldo_seven_enable;
   endproperty
   a_enable_off: assert property (p_enable_off)
      else $error("Regulator stayed on after disable");

   property p_drain_none;
      (wr_c6 && !pwdata[6]) |=> !ldo_six_shutdown_drain;
   endproperty
   a_drain_none: assert property (p_drain_none)
      else $error("Drain active with option cleared");

   property p_quiet_hold;
      !wr_c7 |=> $stable(ldo_seven_quiet_supply_mode);
   endproperty
   a_quiet_hold: assert property (p_quiet_hold)
      else $error("Quiet mode changed without a write");

   property p_pgood_read7;
      (rd_acc && hit_c7) |-> prdata[0] == $past(pg7);
   endproperty
   a_pgood_read7: assert property (p_pgood_read7)
      else $error("Power-good bit of seven read wrong");

   property p_hold_on_drop;
      !power_ok |=> reset_out_n_oe;
   endproperty
   a_hold_on_drop: assert property (p_hold_on_drop)
      else $error("Reset output not pulled on supply loss");

   property p_sys_read;
      (rd_acc && hit_sys) |-> prdata[2] == $past(hold_low) && prdata[1] == $past(power_ok);
   endproperty
   a_sys_read: assert property (p_sys_read)
      else $error("System status read wrong");

   property p_release_flag;
      $fell(reset_out_n_oe) |=> ist_q[`LCR_IRQ_RST_DONE];
   endproperty
   a_release_flag: assert property (p_release_flag)
      else $error("Release event not flagged");

   property p_set_wins;
      pg6_rise |=> ist_q[`LCR_IRQ_SIX_RISE];
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("Power-good rise not flagged");

   property p_w1c;
      (wr_ist && pwdata[`LCR_IRQ_SIX_RISE] && !pg6_rise) |=> !ist_q[`LCR_IRQ_SIX_RISE];
   endproperty
   a_w1c: assert property (p_w1c)
      else $error("Status bit not cleared by write");

   property p_mask_write;
      wr_imk |=> imk_q == $past(pwdata[IW-1:0]);
   endproperty
   a_mask_write: assert property (p_mask_write)
      else $error("Mask not taken from write");

   property p_rd_upper;
      rd_acc |-> prdata[31:8] == 24'h00_0000;
   endproperty
   a_rd_upper: assert property (p_rd_upper)
      else $error("Upper read data not zero");

   property p_unmapped;
      (rd_acc && !hit_any) |-> pslverr && prdata[7:0] == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("Unmapped read not refused");

   c_ctrl_read: cover property (rd_acc && hit_c6);
   c_reset_rel: cover property (rst_done);
   c_irq:       cover property ($rose(irq));
   c_bad_addr:  cover property (pslverr);
   c_pg_fall:   cover property (pg6_fall);
endmodule : lcr_bank

// ==== rtl/lcr_map.svh ====
// Register indices, field positions, reset values and timing counts
`ifndef LCR_MAP_SVH
`define LCR_MAP_SVH

`define LCR_ADDR_W          12
`define LCR_IDX_SIX_VOLT    8'h60
`define LCR_IDX_SIX_CTRL    8'h61
`define LCR_IDX_SEVEN_VOLT  8'h64
`define LCR_IDX_SEVEN_CTRL  8'h65
`define LCR_IDX_IRQ_STATUS  8'h68
`define LCR_IDX_IRQ_MASK    8'h69
`define LCR_IDX_SYS_STATUS  8'h6A
`define LCR_BYTE_ADDR(i)    ({2'b00, (i), 2'b00})

`define LCR_VCODE_MSB       5
`define LCR_CTRL_EN_BIT     7
`define LCR_CTRL_DRAIN_BIT  6
`define LCR_CTRL_QUIET_BIT  5
`define LCR_CTRL_PGOOD_BIT  0
`define LCR_VCODE_RST       6'h00
`define LCR_CTRL_RST        1'b0

`define LCR_IRQ_SIX_RISE    0
`define LCR_IRQ_SIX_FALL    1
`define LCR_IRQ_SEVEN_RISE  2
`define LCR_IRQ_SEVEN_FALL  3
`define LCR_IRQ_RST_DONE    4
`define LCR_IRQ_W           5
`define LCR_IRQ_RST         5'h00

`define LCR_CLK_PERIOD_NS   100
`define LCR_RST_DELAY_US    260000
`define LCR_RST_MIN_US      227900
`define LCR_RST_MAX_US      291200
`define LCR_RST_DELAY_CYC   ((`LCR_RST_DELAY_US * 1000) / `LCR_CLK_PERIOD_NS)
`define LCR_RST_CNT_W       22

`endif

// ==== rtl/lcr_pkg.sv ====
// Types shared by the regulator control bank
package lcr_pkg;
   typedef enum logic [1:0] {
      LCR_RST_WAIT,
      LCR_RST_COUNT,
      LCR_RST_DONE
   } lcr_rst_state_t;
endpackage : lcr_pkg

// ==== rtl/lcr_ldo_chan.sv ====
// One regulator's voltage and control registers with power-good sync
`timescale 1ns/100ps
`include "lcr_map.svh"
module lcr_ldo_chan #(
   parameter logic [5:0] VCODE_RST = `LCR_VCODE_RST
) (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       wr_volt,
   input  wire logic       wr_ctrl,
   input  wire logic [7:0] wdata,
   input  wire logic       pgood_raw,
   output logic      [5:0] voltage_code,
   output logic            enable,
   output logic            drain_on,
   output logic            quiet,
   output logic            pgood,
   output logic      [7:0] volt_rd,
   output logic      [7:0] ctrl_rd,
   output logic            pg_rise,
   output logic            pg_fall
);
   logic [5:0] vcode_q;
   logic       en_q, drain_en_q, quiet_q, drain_on_q;
   logic       pg_meta_q, pg_q, pg_old_q;
   wire        en_d    = wr_ctrl ? wdata[`LCR_CTRL_EN_BIT] : en_q;
   wire        drain_d = wr_ctrl ? wdata[`LCR_CTRL_DRAIN_BIT] : drain_en_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vcode_q    <= VCODE_RST;
         en_q       <= `LCR_CTRL_RST;
         drain_en_q <= `LCR_CTRL_RST;
         quiet_q    <= `LCR_CTRL_RST;
         drain_on_q <= `LCR_CTRL_RST;
      end else begin
         if (wr_volt) begin
            vcode_q <= wdata[`LCR_VCODE_MSB:0];
         end
         en_q       <= en_d;
         drain_en_q <= drain_d;
         drain_on_q <= drain_d & ~en_d;
         if (wr_ctrl) begin
            quiet_q <= wdata[`LCR_CTRL_QUIET_BIT];
         end
      end
   end

   // Analog comparator is asynchronous to pclk
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pg_meta_q <= 1'b0;
         pg_q      <= 1'b0;
         pg_old_q  <= 1'b0;
      end else begin
         pg_meta_q <= pgood_raw;
         pg_q      <= pg_meta_q;
         pg_old_q  <= pg_q;
      end
   end

   assign voltage_code = vcode_q;
   assign enable       = en_q;
   assign drain_on     = drain_on_q;
   assign quiet        = quiet_q;
   assign pgood        = pg_q;
   assign pg_rise      = pg_q & ~pg_old_q;
   assign pg_fall      = ~pg_q & pg_old_q;
   assign volt_rd      = {2'b00, vcode_q};
   assign ctrl_rd      = {en_q, drain_en_q, quiet_q, 4'h0, pg_q};
endmodule : lcr_ldo_chan

// ==== rtl/lcr_rst_timer.sv ====
// Hold timer for the open-drain reset output
`timescale 1ns/100ps
`include "lcr_map.svh"
module lcr_rst_timer #(
   parameter int unsigned DELAY_CYC = `LCR_RST_DELAY_CYC
) (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic power_ok,
   output logic      hold_low,
   output logic      released
);
   localparam int CW = `LCR_RST_CNT_W;
   lcr_pkg::lcr_rst_state_t state_q, state_d;
   logic [CW-1:0] cnt_q, cnt_d;
   logic          hold_q, rel_q;
   wire           last = (cnt_q == CW'(DELAY_CYC - 1));

   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      case (state_q)
         lcr_pkg::LCR_RST_WAIT: begin
            cnt_d = '0;
            if (power_ok) begin
               state_d = lcr_pkg::LCR_RST_COUNT;
            end
         end
         lcr_pkg::LCR_RST_COUNT: begin
            // Supply dip restarts the full delay
            if (!power_ok) begin
               state_d = lcr_pkg::LCR_RST_WAIT;
            end else if (last) begin
               state_d = lcr_pkg::LCR_RST_DONE;
            end else begin
               cnt_d = cnt_q + CW'(1);
            end
         end
         lcr_pkg::LCR_RST_DONE: begin
            if (!power_ok) begin
               state_d = lcr_pkg::LCR_RST_WAIT;
            end
         end
         default: state_d = lcr_pkg::LCR_RST_WAIT;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= lcr_pkg::LCR_RST_WAIT;
         cnt_q   <= '0;
         hold_q  <= 1'b1;
         rel_q   <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         hold_q  <= (state_d != lcr_pkg::LCR_RST_DONE);
         rel_q   <= (state_q == lcr_pkg::LCR_RST_COUNT) && (state_d == lcr_pkg::LCR_RST_DONE);
      end
   end

   assign hold_low = hold_q;
   assign released = rel_q;

   property p_release_delay;
      @(posedge pclk) disable iff (!presetn)
      $fell(hold_q) |-> $past(cnt_q) == CW'(DELAY_CYC - 1);
   endproperty
   a_release_delay: assert property (p_release_delay)
      else $error("Reset released before full delay");

   property p_hold_until_done;
      @(posedge pclk) disable iff (!presetn)
      (state_q != lcr_pkg::LCR_RST_DONE) |-> hold_q;
   endproperty
   a_hold_until_done: assert property (p_hold_until_done)
      else $error("Reset output not held while counting");
endmodule : lcr_rst_timer

// ==== tb/testbench.sv ====
// Self-checking bench for the regulator control register bank
`timescale 1ns/100ps
`include "lcr_map.svh"
module testbench;
   localparam int unsigned DLY = 20;
   logic        pclk;
   logic        presetn;
   logic [11:0] paddr;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [31:0] pwdata;
   logic [3:0]  pstrb;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        irq;
   logic        pg_six;
   logic        pg_seven;
   logic [5:0]  six_code;
   logic        six_en;
   logic        six_drain;
   logic        six_quiet;
   logic [5:0]  seven_code;
   logic        seven_en;
   logic        seven_drain;
   logic        seven_quiet;
   wire         rst_pin;
   logic        rst_out;
   logic        rst_oe;
   int          n_mismatch;
   int          samples_checked;
   int          seed;
   int          n;
   logic [31:0] rd;
   logic [31:0] d;
   logic        err;
   logic        pg;
   logic [11:0] va;
   logic [11:0] ca;

   // Open-drain pin with external pull-up
   assign rst_pin = rst_oe ? rst_out : 1'b1;

   lcr_bank #(.RST_DELAY_CYC(DLY)) dut (
      .pclk                        (pclk),
      .presetn                     (presetn),
      .paddr                       (paddr),
      .psel                        (psel),
      .penable                     (penable),
      .pwrite                      (pwrite),
      .pwdata                      (pwdata),
      .pstrb                       (pstrb),
      .prdata                      (prdata),
      .pready                      (pready),
      .pslverr                     (pslverr),
      .irq                         (irq),
      .ldo_six_pgood_in            (pg_six),
      .ldo_seven_pgood_in          (pg_seven),
      .ldo_six_voltage_code        (six_code),
      .ldo_six_enable              (six_en),
      .ldo_six_shutdown_drain      (six_drain),
      .ldo_six_quiet_supply_mode   (six_quiet),
      .ldo_seven_voltage_code      (seven_code),
      .ldo_seven_enable            (seven_en),
      .ldo_seven_shutdown_drain    (seven_drain),
      .ldo_seven_quiet_supply_mode (seven_quiet),
      .reset_out_n_in              (rst_pin),
      .reset_out_n_out             (rst_out),
      .reset_out_n_oe              (rst_oe)
   );

   always #50 pclk = ~pclk;

   task automatic wrap_up();
      $display("Checks %0d, mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : wrap_up

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // Waits on pready rather than assuming the zero-wait answer
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int k;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 16);
      if (pready !== 1'b1) begin
         n_mismatch++;
         wrap_up();
      end
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      check(what, rd, exp);
   endtask : rdchk

   // Counts falling edges with the reset pin still pulled low
   task automatic hold_count();
      n = 0;
      @(negedge pclk);
      while (rst_oe === 1'b1 && n < 100) begin
         n++;
         @(negedge pclk);
      end
      if (n >= 100) begin
         n_mismatch++;
         wrap_up();
      end
   endtask : hold_count

   function automatic logic [31:0] exp_ctrl(input logic [31:0] w, input logic p);
      return {24'h0000_00, w[7:5], 4'h0, p};
   endfunction : exp_ctrl

   initial begin
      pclk     = 1'b0;
      presetn  = 1'b0;
      psel     = 1'b0;
      penable  = 1'b0;
      pwrite   = 1'b0;
      paddr    = 12'h000;
      pwdata   = 32'h0000_0000;
      pstrb    = 4'hf;
      pg_six   = 1'b0;
      pg_seven = 1'b0;
      n_mismatch      = 0;
      samples_checked = 0;
      seed = 32'hd742_7ced;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      check("pin driven low", rst_pin, 1'b0);
      check("drive level", rst_out, 1'b0);
      hold_count();
      check("hold long enough", n >= DLY && n <= DLY + 3, 1'b1);
      rdchk("six volt reset", `LCR_BYTE_ADDR(`LCR_IDX_SIX_VOLT), 32'h0);
      rdchk("seven ctrl reset", `LCR_BYTE_ADDR(`LCR_IDX_SEVEN_CTRL), 32'h0);
      rdchk("sys status", `LCR_BYTE_ADDR(`LCR_IDX_SYS_STATUS), 32'h3);
      rdchk("irq status", `LCR_BYTE_ADDR(`LCR_IDX_IRQ_STATUS), 32'h10);
      check("irq masked", irq, 1'b0);
      apb(1'b1, `LCR_BYTE_ADDR(`LCR_IDX_IRQ_MASK), 32'h10);
      @(negedge pclk);
      check("irq unmasked", irq, 1'b1);
      apb(1'b1, `LCR_BYTE_ADDR(`LCR_IDX_IRQ_STATUS), 32'h10);
      @(negedge pclk);
      check("irq cleared", irq, 1'b0);
      // Enabling a regulator that is not yet good must pull reset again
      apb(1'b1, `LCR_BYTE_ADDR(`LCR_IDX_SIX_CTRL), 32'h80);
      repeat (3) @(negedge pclk);
      check("reset reasserted", rst_pin, 1'b0);
      @(posedge pclk);
      pg_six <= 1'b1;
      hold_count();
      check("hold after restart", n >= DLY && n <= DLY + 6, 1'b1);
      rdchk("six ctrl pg", `LCR_BYTE_ADDR(`LCR_IDX_SIX_CTRL), 32'h81);
      apb(1'b1, `LCR_BYTE_ADDR(`LCR_IDX_IRQ_MASK), 32'h01);
      @(negedge pclk);
      check("irq on pg rise", irq, 1'b1);
      apb(1'b1, `LCR_BYTE_ADDR(`LCR_IDX_IRQ_STATUS), 32'h1f);
      apb(1'b0, 12'h1fc, 32'h0);
      check("unmapped err", err, 1'b1);
      check("unmapped data", rd, 32'h0);
      // Supply loss sets the fall bit; a write without lane 0 is dropped
      @(posedge pclk);
      pg_six <= 1'b0;
      pstrb  <= 4'h0;
      repeat (4) @(posedge pclk);
      rdchk("six fall status", `LCR_BYTE_ADDR(`LCR_IDX_IRQ_STATUS), 32'h2);
      apb(1'b1, `LCR_BYTE_ADDR(`LCR_IDX_SIX_VOLT), 32'h3f);
      pstrb <= 4'hf;
      rdchk("strobe ignored", `LCR_BYTE_ADDR(`LCR_IDX_SIX_VOLT), 32'h0);
      // Corner values first, then random traffic on both channels
      for (int i = 0; i < 24; i++) begin
         d  = (i == 0) ? 32'hffff_ffff : (i == 1) ? 32'h0000_005f : $random(seed);
         pg = d[31];
         va = d[30] ? `LCR_BYTE_ADDR(`LCR_IDX_SEVEN_VOLT) : `LCR_BYTE_ADDR(`LCR_IDX_SIX_VOLT);
         ca = d[30] ? `LCR_BYTE_ADDR(`LCR_IDX_SEVEN_CTRL) : `LCR_BYTE_ADDR(`LCR_IDX_SIX_CTRL);
         @(posedge pclk);
         if (d[30]) begin
            pg_seven <= pg;
         end else begin
            pg_six <= pg;
         end
         apb(1'b1, va, d);
         apb(1'b1, ca, d);
         repeat (3) @(posedge pclk);
         rdchk("volt readback", va, {26'h0, d[5:0]});
         rdchk("ctrl readback", ca, exp_ctrl(d, pg));
         @(negedge pclk);
         if (d[30]) begin
            check("seven code", seven_code, d[5:0]);
            check("seven on", seven_en, d[7]);
            check("seven drain", seven_drain, d[6] & ~d[7]);
            check("seven quiet", seven_quiet, d[5]);
         end else begin
            check("six code", six_code, d[5:0]);
            check("six on", six_en, d[7]);
            check("six drain", six_drain, d[6] & ~d[7]);
            check("six quiet", six_quiet, d[5]);
         end
         check("drive level", rst_out, 1'b0);
      end
      wrap_up();
   end
endmodule : testbench
